//--- verilog/wrw_watchdog.sv
// Windowed reset watchdog with APB register access.
//
// Overview of operation
// - The seven-bit count steps down once every 131072 clock cycles.
// - When armed, stepping the count from 40h to 3Fh requests a reset.
// - The count keeps stepping down even while the watchdog is disarmed.
// - Writing the arm bit as one with the timeout bit zero resets at once.
// - In software mode the watchdog leaves reset disarmed and stays armed.
// - In hardware mode the watchdog is always armed, whatever the arm bit.
// - Wait mode changes nothing: counting and resetting carry on.
// - Entering halt steps the count once, then freezes it with no reset.
// - An external wake resumes counting after 512 clocks.
// - Software can set the arm bit but only a reset clears it.
// - After reset the control register reads 7Fh.
// - At 15 MHz a load of FFh times out in 559.2 ms and C0h in 8.73 ms.
`default_nettype none

module wrw_watchdog #(
  parameter int unsigned PRESCALE = wrw_pkg::PRESCALE_CYCLES
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Option byte and power mode events from the core.
  input wire logic i_hw_option,
  input wire logic i_halt_enter,
  input wire logic i_ext_wake,
  // Reset request to the reset sequencer.
  output logic o_wdg_reset
);

  localparam int unsigned GW = $clog2(PRESCALE) + 1;

  typedef struct packed {
    logic arm;
    logic [6:0] cnt;
    logic hw_opt;
    logic strap_done;
    wrw_pkg::wrw_mode_t mode;
    logic [8:0] wake;
    logic rst_req;
    logic [31:0] rdata;
    logic [GW-1:0] gap;
    logic [9:0] wake_seen;
  } wrw_state_t;

  wrw_state_t st;
  wrw_state_t next_st;

  logic tick;
  logic wr_ctrl;
  logic armed;
  logic restart;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.
  if (PRESCALE < 2) begin : g_bad_prescale
    $error("Prescale must be at least two cycles.");
  end

  if ((((longint'(wrw_pkg::TIMEOUT_STEPS) *
         longint'(wrw_pkg::PRESCALE_CYCLES) * 64'd1_000_000) /
        wrw_pkg::REF_CPU_HZ) / 64'd100) * 64'd100 !=
      wrw_pkg::TIMEOUT_MAX_US) begin : g_bad_max
    $error("Longest timeout does not match the reference.");
  end

  if ((((longint'(wrw_pkg::PRESCALE_CYCLES) * 64'd1_000_000) /
        wrw_pkg::REF_CPU_HZ) / 64'd10) * 64'd10 !=
      wrw_pkg::TIMEOUT_MIN_US) begin : g_bad_min
    $error("Shortest timeout does not match the reference.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  function automatic logic addr_is(input logic [7:0] addr,
                                   input logic [5:0] index);
    addr_is = (addr[7:2] == index);
  endfunction

  function automatic logic [6:0] step_down(input logic [6:0] value);
    step_down = value - 7'h01;
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] addr,
                                           input wrw_state_t s);
    read_mux = 32'h0000_0000;
    if (addr_is(addr, wrw_pkg::CTRL_INDEX))
    begin
      read_mux[7:0] = {s.arm, s.cnt};
    end
    else if (addr_is(addr, wrw_pkg::STAT_INDEX))
    begin
      read_mux[wrw_pkg::STAT_HWOPT_BIT] = s.hw_opt;
      read_mux[wrw_pkg::STAT_HALT_BIT] = (s.mode != wrw_pkg::WRW_RUN);
      read_mux[wrw_pkg::STAT_WAKE_BIT] = (s.mode == wrw_pkg::WRW_WAKE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, answering in the first access cycle.
  assign o_pready = i_penable;
  assign o_pslverr = i_psel && i_penable &&
                     !addr_is(i_paddr, wrw_pkg::CTRL_INDEX) &&
                     !addr_is(i_paddr, wrw_pkg::STAT_INDEX);
  assign o_prdata = st.rdata;
  assign wr_ctrl = i_psel && i_penable && i_pwrite &&
                   addr_is(i_paddr, wrw_pkg::CTRL_INDEX);
  assign o_wdg_reset = st.rst_req;

  ////////////////////////////////////////////////////////////////////////////
  // Step generator.
  assign armed = st.arm || st.hw_opt;
  assign restart = wr_ctrl || (st.mode != wrw_pkg::WRW_RUN);

  wrw_prescaler #(
    .DIV(PRESCALE)
  ) u_prescaler (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_restart(restart),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    next_st = st;
    next_st.rst_req = 1'b0;
    if (!st.strap_done)
    begin
      next_st.hw_opt = i_hw_option;
      next_st.strap_done = 1'b1;
    end
    unique case (st.mode)
      wrw_pkg::WRW_RUN:
      begin
        if (tick)
        begin
          next_st.cnt = step_down(st.cnt);
          if (armed && st.cnt == wrw_pkg::ROLL_FROM)
          begin
            next_st.rst_req = 1'b1;
          end
        end
        if (i_halt_enter)
        begin
          next_st.mode = wrw_pkg::WRW_HALT_STEP;
        end
      end
      wrw_pkg::WRW_HALT_STEP:
      begin
        next_st.cnt = step_down(st.cnt);
        next_st.mode = wrw_pkg::WRW_HALTED;
      end
      wrw_pkg::WRW_HALTED:
      begin
        if (i_ext_wake)
        begin
          next_st.mode = wrw_pkg::WRW_WAKE;
          next_st.wake = 9'h000;
        end
      end
      wrw_pkg::WRW_WAKE:
      begin
        next_st.wake = st.wake + 9'h001;
        if (st.wake == 9'(wrw_pkg::WAKE_DELAY_CYCLES - 1))
        begin
          next_st.mode = wrw_pkg::WRW_RUN;
        end
      end
    endcase
    if (wr_ctrl)
    begin
      next_st.arm = st.arm || i_pwdata[wrw_pkg::ARM_BIT];
      next_st.cnt = i_pwdata[6:0];
      if (i_pwdata[wrw_pkg::ARM_BIT] && !i_pwdata[wrw_pkg::TIMEOUT_BIT])
      begin
        next_st.rst_req = 1'b1;
      end
    end
    if (i_psel && !i_penable)
    begin
      next_st.rdata = read_mux(i_paddr, st);
    end
    if (restart || tick)
    begin
      next_st.gap = '0;
    end
    else
    begin
      next_st.gap = st.gap + GW'(1);
    end
    if (st.mode == wrw_pkg::WRW_WAKE)
    begin
      next_st.wake_seen = st.wake_seen + 10'h001;
    end
    else
    begin
      next_st.wake_seen = 10'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st.arm <= 1'b0;
      st.cnt <= wrw_pkg::CTRL_RESET[6:0];
      st.hw_opt <= 1'b0;
      st.strap_done <= 1'b0;
      st.mode <= wrw_pkg::WRW_RUN;
      st.wake <= 9'h000;
      st.rst_req <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.gap <= '0;
      st.wake_seen <= 10'h000;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge i_core_clk);
  endclocking

  default disable iff (!i_resetn);

  sequence s_halt_entry;
    st.mode == wrw_pkg::WRW_RUN && i_halt_enter && !wr_ctrl;
  endsequence

  sequence s_halt_steps;
    st.mode == wrw_pkg::WRW_HALT_STEP ##1 st.mode == wrw_pkg::WRW_HALTED;
  endsequence

  sequence s_roll_armed;
    st.mode == wrw_pkg::WRW_RUN && tick && !wr_ctrl && armed &&
    st.cnt == wrw_pkg::ROLL_FROM;
  endsequence

  AST_TICK_SPACING: assert property (
    (st.mode == wrw_pkg::WRW_RUN && tick && !wr_ctrl) |->
      st.gap == GW'(PRESCALE - 1))
    else $error("Count step came at the wrong spacing.");

  AST_ROLL_RESET: assert property (
    s_roll_armed |=> o_wdg_reset && st.cnt == wrw_pkg::ROLL_TO)
    else $error("Armed roll from 40h gave no reset.");

  AST_FREE_RUN: assert property (
    (st.mode == wrw_pkg::WRW_RUN && tick && !wr_ctrl && !i_halt_enter &&
     !armed) |=> st.cnt == step_down($past(st.cnt)) && !o_wdg_reset)
    else $error("Disarmed count did not step down alone.");

  AST_SW_RESET: assert property (
    (wr_ctrl && i_pwdata[wrw_pkg::ARM_BIT] &&
     !i_pwdata[wrw_pkg::TIMEOUT_BIT]) |=> o_wdg_reset ##1 !o_wdg_reset)
    else $error("Software reset write gave no single reset pulse.");

  AST_ARM_STICKY: assert property (
    st.arm |=> st.arm)
    else $error("Arm bit cleared without a reset.");

  AST_HW_ALWAYS: assert property (
    (st.hw_opt && !st.arm && st.mode == wrw_pkg::WRW_RUN && tick &&
     !wr_ctrl && st.cnt == wrw_pkg::ROLL_FROM) |=> o_wdg_reset)
    else $error("Hardware mode roll gave no reset.");

  AST_HALT_ENTRY: assert property (
    s_halt_entry ##1 (st.mode == wrw_pkg::WRW_HALT_STEP && !wr_ctrl) |=>
      st.mode == wrw_pkg::WRW_HALTED && st.cnt == step_down($past(st.cnt)))
    else $error("Halt entry did not step once and stop.");

  AST_HALT_SEQ: assert property (
    s_halt_entry |=> s_halt_steps)
    else $error("Halt entry sequence broken.");

  AST_HALT_FROZEN: assert property (
    (st.mode == wrw_pkg::WRW_HALTED && !wr_ctrl) |=>
      $stable(st.cnt) && !o_wdg_reset)
    else $error("Count moved or reset fired while halted.");

  AST_WAKE_DELAY: assert property (
    (st.mode == wrw_pkg::WRW_WAKE &&
     next_st.mode == wrw_pkg::WRW_RUN) |->
      st.wake_seen == 10'(wrw_pkg::WAKE_DELAY_CYCLES - 1))
    else $error("Wake delay was not 512 clocks.");

  AST_RESET_VALUE: assert property (
    @(posedge i_core_clk) disable iff (1'b0)
    !i_resetn |-> {st.arm, st.cnt} == wrw_pkg::CTRL_RESET &&
                  !o_wdg_reset)
    else $error("Control register wrong during reset.");

  AST_WRITE_LOAD: assert property (
    wr_ctrl |=> st.cnt == $past(i_pwdata[6:0]) &&
                st.arm == ($past(st.arm) || $past(i_pwdata[7])) &&
                st.gap == '0)
    else $error("Control write did not load and restart.");

  AST_HALT_ROLL_QUIET: assert property (
    (st.mode == wrw_pkg::WRW_HALT_STEP && !wr_ctrl &&
     st.cnt == wrw_pkg::ROLL_FROM) |=>
      st.cnt == wrw_pkg::ROLL_TO && !o_wdg_reset)
    else $error("Halt step through 40h gave a reset.");

  AST_RESET_PULSE: assert property (
    (o_wdg_reset && !wr_ctrl) |=> !o_wdg_reset)
    else $error("Reset request lasted more than one cycle.");

  AST_STRAP_FIXED: assert property (
    st.strap_done |=> $stable(st.hw_opt))
    else $error("Watchdog option changed without a reset.");

  AST_CTRL_READ: assert property (
    (i_psel && !i_penable && addr_is(i_paddr, wrw_pkg::CTRL_INDEX)) |=>
      o_prdata == {24'h00_0000, $past(st.arm), $past(st.cnt)})
    else $error("Control register read returned the wrong value.");

endmodule

`default_nettype wire

//--- verilog/wrw_pkg.sv
// Constants and types shared by the windowed reset watchdog.
`default_nettype none

package wrw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PRESCALE_CYCLES = 131072;
  localparam int unsigned WAKE_DELAY_CYCLES = 512;
  localparam int unsigned TIMEOUT_STEPS = 64;

  // Reference timeouts at the reference CPU rate, in microseconds.
  localparam longint unsigned REF_CPU_HZ = 15_000_000;
  localparam longint unsigned TIMEOUT_MAX_US = 559200;
  localparam longint unsigned TIMEOUT_MIN_US = 8730;
  localparam logic [7:0] LOAD_MAX = 8'hff;
  localparam logic [7:0] LOAD_MIN = 8'hc0;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: word indices, byte address is four times the index.
  localparam logic [5:0] CTRL_INDEX = 6'h35;
  localparam logic [5:0] STAT_INDEX = 6'h36;

  // Control register layout and reset value.
  localparam int unsigned ARM_BIT = 7;
  localparam int unsigned TIMEOUT_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h7f;
  localparam logic [6:0] ROLL_FROM = 7'h40;
  localparam logic [6:0] ROLL_TO = 7'h3f;

  // Status register layout.
  localparam int unsigned STAT_HWOPT_BIT = 0;
  localparam int unsigned STAT_HALT_BIT = 1;
  localparam int unsigned STAT_WAKE_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Power mode tracking, Gray coded along run, halt, wake.
  typedef enum logic [1:0] {
    WRW_RUN = 2'b00,
    WRW_HALT_STEP = 2'b01,
    WRW_HALTED = 2'b11,
    WRW_WAKE = 2'b10
  } wrw_mode_t;

endpackage

`default_nettype wire

//--- verilog/wrw_prescaler.sv
// Prescaler that yields one tick every DIV cycles.
`default_nettype none

module wrw_prescaler #(
  parameter int unsigned DIV = 131072
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Control.
  input wire logic i_restart,
  // Tick out.
  output logic o_tick
);

  localparam int unsigned W = $clog2(DIV);

  typedef struct packed {
    logic [W-1:0] cnt;
  } wrw_pre_state_t;

  wrw_pre_state_t st;
  wrw_pre_state_t next_st;

  if (DIV < 2) begin : g_bad_div
    $error("Prescale division must be at least two.");
  end

  assign o_tick = !i_restart && (st.cnt == W'(DIV - 1));

  always_comb
  begin
    next_st = st;
    if (i_restart)
    begin
      next_st.cnt = '0;
    end
    else if (o_tick)
    begin
      next_st.cnt = '0;
    end
    else
    begin
      next_st.cnt = st.cnt + W'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

`default_nettype wire

//--- test/wrw_watchdog_test.sv
// Self-checking testbench for the windowed reset watchdog.
`default_nettype none

module wrw_watchdog_test;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Signals, counters and addresses.
  localparam int PS = 16;
  localparam logic [7:0] CA = {wrw_pkg::CTRL_INDEX, 2'b00};
  localparam logic [7:0] SA = {wrw_pkg::STAT_INDEX, 2'b00};
  logic clk = 1'b0;
  logic rstn = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic hwopt = 1'b0;
  logic halt = 1'b0;
  logic wake = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rdat;
  logic rerr;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic wdrst;
  int miscompares = 0;
  int samples_checked = 0;
  int pulses = 0;
  int last_cyc = 0;
  int cyc = 0;
  int t0;
  int p0;

  wrw_watchdog #(.PRESCALE(PS)) u_dut (
    .i_core_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_hw_option(hwopt),
    .i_halt_enter(halt), .i_ext_wake(wake), .o_wdg_reset(wdrst)
  );

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // Counts cycles and records every reset request pulse.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (wdrst === 1'b1)
    begin
      pulses <= pulses + 1;
      last_cyc <= cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus and reset tasks.
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
  endtask

  task automatic wait_pulse(input int lim);
    int n;
    n = 0;
    while (pulses == p0 && n < lim)
    begin
      n++;
      @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    apb(1'b0, CA, 32'h0);
    check_word(rdat, 32'h7f);
    apb(1'b0, 8'h00, 32'h0);
    check_bit(rerr, 1'b1);
    check_word(rdat, 32'h0);
    apb(1'b0, SA, 32'h0);
    check_word(rdat, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_free_run();
    p0 = pulses;
    apb(1'b1, CA, 32'h45);
    repeat (87) @(posedge clk);
    apb(1'b0, CA, 32'h0);
    check_word(rdat, 32'h40);
    repeat (15) @(posedge clk);
    apb(1'b0, CA, 32'h0);
    check_word(rdat, 32'h3f);
    check_bit(pulses == p0, 1'b1);
    $display("test free_run done");
  endtask

  task automatic t_armed();
    p0 = pulses;
    apb(1'b1, CA, 32'hc7);
    apb(1'b1, CA, 32'h42);
    t0 = cyc;
    apb(1'b0, CA, 32'h0);
    check_word(rdat, 32'hc2);
    wait_pulse(200);
    check_bit(last_cyc - t0 >= 47 && last_cyc - t0 <= 51, 1'b1);
    do_reset();
    apb(1'b0, CA, 32'h0);
    check_word(rdat, 32'h7f);
    $display("test armed done");
  endtask

  task automatic t_soft_reset();
    apb(1'b1, CA, 32'h80);
    @(negedge clk);
    check_bit(wdrst, 1'b1);
    @(negedge clk);
    check_bit(wdrst, 1'b0);
    do_reset();
    $display("test soft_reset done");
  endtask

  task automatic t_halt();
    p0 = pulses;
    apb(1'b1, CA, 32'hc5);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    repeat (200) @(posedge clk);
    check_bit(pulses == p0, 1'b1);
    apb(1'b0, CA, 32'h0);
    check_word(rdat, 32'hc4);
    apb(1'b0, SA, 32'h0);
    check_word(rdat, 32'h2);
    wake <= 1'b1;
    t0 = cyc;
    @(posedge clk);
    wake <= 1'b0;
    repeat (400) @(posedge clk);
    apb(1'b0, SA, 32'h0);
    check_word(rdat, 32'h6);
    wait_pulse(800);
    check_bit(last_cyc - t0 >= 586 && last_cyc - t0 <= 600, 1'b1);
    p0 = pulses;
    apb(1'b1, CA, 32'hc0);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    repeat (100) @(posedge clk);
    check_bit(pulses == p0, 1'b1);
    apb(1'b0, CA, 32'h0);
    check_word(rdat, 32'hbf);
    do_reset();
    apb(1'b0, SA, 32'h0);
    check_word(rdat, 32'h0);
    apb(1'b0, CA, 32'h0);
    check_word(rdat, 32'h7f);
    $display("test halt done");
  endtask

  task automatic t_hw_option();
    hwopt <= 1'b1;
    do_reset();
    p0 = pulses;
    apb(1'b1, CA, 32'h42);
    t0 = cyc;
    apb(1'b0, SA, 32'h0);
    check_word(rdat, 32'h1);
    wait_pulse(200);
    check_bit(last_cyc - t0 >= 47 && last_cyc - t0 <= 51, 1'b1);
    $display("test hw_option done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog.
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_free_run();
    t_armed();
    t_soft_reset();
    t_halt();
    t_hw_option();
    results();
  end

  initial
  begin
    #300000;
    miscompares++;
    results();
  end

endmodule

`default_nettype wire
